// *** include/dwt_pkg.sv ***
// Shared constants and carrier types for the dual watchdog block.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
package dwt_pkg;

    // Clock rate and the watchdog timebase derived from it
    localparam int unsigned CLK_HZ   = 10_000_000;
    localparam int unsigned TB_HZ    = 1_500_000;
    localparam int unsigned TB_GRAN  = 500_000;
    localparam int unsigned TB_STEP  = TB_HZ / TB_GRAN;
    localparam int unsigned TB_WRAP  = CLK_HZ / TB_GRAN;

    // Widths
    localparam int unsigned CNT_W    = 32;
    localparam int unsigned ACC_W    = 5;

    // Accumulator step, wrap point and reset values
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TB_STEP);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(TB_WRAP);
    localparam logic [ACC_W-1:0] ACC_RST  = 5'h00;
    localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

    // Run state of either watchdog
    typedef enum logic {
        WD_IDLE,
        WD_RUN
    } dwt_state_t;

    // Software controls of the system watchdog
    typedef struct packed {
        logic start;
        logic stopReq;
        logic reload;
        logic intClear;
        logic resetEn;
    } dwt_sys_ctrl_t;

    // Software controls of the always-on guard timer
    typedef struct packed {
        logic start;
        logic stopReq;
        logic reload;
        logic pauseEn;
    } dwt_aon_ctrl_t;

    // System watchdog status
    typedef struct packed {
        logic             running;
        logic             irq;
        logic             resetReq;
        logic [CNT_W-1:0] count;
    } dwt_sys_stat_t;

    // Always-on guard timer status
    typedef struct packed {
        logic             running;
        logic             resetReq;
        logic [CNT_W-1:0] count;
    } dwt_aon_stat_t;

endpackage

// *** hw/dwt_top.sv ***
// System watchdog and always-on guard timer, both on one 1.5 MHz timebase.
// Assumes all inputs synchronous to clk; reset requests stay high until rst.
//
// Overview of operation
// - System watchdog ticks at 1.5 MHz
// - Enabled system watchdog ignores stop requests
// - System watchdog keeps counting during standby
// - Debug halt freezes system watchdog count
// - Missed service raises interrupt, can force reset
// - Guard timer resets device at zero
// - Started guard timer cannot be stopped
// - Guard timer keeps counting during standby
// - Guard timer optionally pauses on debug halt
module dwt_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Debugger halt, level
    input  wire logic                  debugHalt,
    // System watchdog
    input  wire logic [dwt_pkg::CNT_W-1:0] sysLoad,
    input  wire dwt_pkg::dwt_sys_ctrl_t    sysCtrl,
    output dwt_pkg::dwt_sys_stat_t         sysStat,
    // Always-on guard timer
    input  wire logic [dwt_pkg::CNT_W-1:0] aonLoad,
    input  wire dwt_pkg::dwt_aon_ctrl_t    aonCtrl,
    output dwt_pkg::dwt_aon_stat_t         aonStat,
    // Combined device reset request
    output logic                       devResetReq
);
    import dwt_pkg::*;

    logic [ACC_W-1:0] acc_q,  acc_d;
    logic             tick_q, tick_d;

    dwt_state_t       sysState_q, sysState_d;
    logic [CNT_W-1:0] sysCnt_q,   sysCnt_d;
    logic             sysIrq_q,   sysIrq_d;
    logic             sysRst_q,   sysRst_d;
    logic             sysExpire;
    logic             sysAdvance;

    dwt_state_t       aonState_q, aonState_d;
    logic [CNT_W-1:0] aonCnt_q,   aonCnt_d;
    logic             aonRst_q,   aonRst_d;
    logic             aonExpire;
    logic             aonAdvance;

    logic             devRst_q,   devRst_d;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Fractional divider: 3 ticks per 20 clocks, exact 1.5 MHz on average
    always_comb begin
        logic [ACC_W-1:0] sum;
        sum    = acc_q + ACC_STEP;
        acc_d  = sum;
        tick_d = 1'b0;
        if (sum >= ACC_WRAP) begin
            acc_d  = sum - ACC_WRAP;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q  <= ACC_RST;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    // Jitter of one clock is the price of not needing a second clock
    property p_tick_rate;
        tick_q |-> ##1 (!tick_q) [*5] ##[1:2] tick_q;
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("timebase tick spacing not 6 or 7 clocks");

    // System watchdog: standby has no effect, only the debug halt gates it
    assign sysAdvance = (sysState_q == WD_RUN) && tick_q
                        && !debugHalt;
    assign sysExpire  = sysAdvance && (sysCnt_q == CNT_RST);

    always_comb begin
        sysState_d = sysState_q;
        sysCnt_d   = sysCnt_q;
        sysIrq_d   = sysIrq_q;
        sysRst_d   = sysRst_q;
        case (sysState_q)
            WD_IDLE: begin
                if (sysCtrl.start) begin
                    sysState_d = WD_RUN;
                    sysCnt_d   = sysLoad;
                end
            end
            WD_RUN: begin
                // No path back to idle: stop requests are not looked at
                sysState_d = WD_RUN;
                if (sysCtrl.reload) begin
                    sysCnt_d = sysLoad;
                end else if (sysExpire) begin
                    sysCnt_d = sysLoad;
                end else if (sysAdvance) begin
                    sysCnt_d = sysCnt_q - CNT_ONE;
                end
                if (sysCtrl.reload || sysCtrl.intClear) begin
                    sysIrq_d = 1'b0;
                end
                // Expiry wins over a clear in the same cycle
                if (sysExpire) begin
                    sysIrq_d = 1'b1;
                    if (sysIrq_q && !sysCtrl.intClear && !sysCtrl.reload
                        && sysCtrl.resetEn) begin
                        sysRst_d = 1'b1;
                    end
                end
            end
            default: begin
                sysState_d = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sysState_q <= WD_IDLE;
            sysCnt_q   <= CNT_RST;
            sysIrq_q   <= 1'b0;
            sysRst_q   <= 1'b0;
        end else begin
            sysState_q <= sysState_d;
            sysCnt_q   <= sysCnt_d;
            sysIrq_q   <= sysIrq_d;
            sysRst_q   <= sysRst_d;
        end
    end

    sequence s_sysArmed;
        sysExpire && !sysIrq_q;
    endsequence

    sequence s_sysSecond;
        sysExpire && sysIrq_q && !sysCtrl.intClear && !sysCtrl.reload
            && sysCtrl.resetEn;
    endsequence

    property p_sys_keep_running;
        (sysState_q == WD_RUN) && sysCtrl.stopReq |=> (sysState_q == WD_RUN);
    endproperty
    a_sys_keep_running: assert property (p_sys_keep_running)
        else $error("system watchdog stopped after enable");

    property p_sys_counts;
        sysAdvance && !sysCtrl.reload && (sysCnt_q != CNT_RST)
            |=> sysCnt_q == $past(sysCnt_q) - CNT_ONE;
    endproperty
    a_sys_counts: assert property (p_sys_counts)
        else $error("system watchdog did not decrement on tick");

    property p_sys_halt;
        (sysState_q == WD_RUN) && debugHalt && !sysCtrl.reload
            |=> $stable(sysCnt_q);
    endproperty
    a_sys_halt: assert property (p_sys_halt)
        else $error("system watchdog moved during debug halt");

    property p_sys_irq;
        s_sysArmed |=> sysIrq_q && $stable(sysRst_q);
    endproperty
    a_sys_irq: assert property (p_sys_irq)
        else $error("first expiry did not raise interrupt alone");

    property p_sys_reset;
        s_sysSecond |=> sysRst_q ##1 devResetReq;
    endproperty
    a_sys_reset: assert property (p_sys_reset)
        else $error("second expiry did not force reset");

    property p_sys_reload;
        (sysState_q == WD_RUN) && sysCtrl.reload && !sysExpire
            |=> sysCnt_q == $past(sysLoad) && !sysIrq_q;
    endproperty
    a_sys_reload: assert property (p_sys_reload)
        else $error("system reload did not restart count");

    // Always-on guard timer
    assign aonAdvance = (aonState_q == WD_RUN) && tick_q
                        && !(debugHalt && aonCtrl.pauseEn);
    assign aonExpire  = aonAdvance && (aonCnt_q == CNT_RST);

    always_comb begin
        aonState_d = aonState_q;
        aonCnt_d   = aonCnt_q;
        aonRst_d   = aonRst_q;
        case (aonState_q)
            WD_IDLE: begin
                if (aonCtrl.start) begin
                    aonState_d = WD_RUN;
                    aonCnt_d   = aonLoad;
                end
            end
            WD_RUN: begin
                aonState_d = WD_RUN;
                if (aonCtrl.reload) begin
                    aonCnt_d = aonLoad;
                end else if (aonAdvance && aonCnt_q != CNT_RST) begin
                    aonCnt_d = aonCnt_q - CNT_ONE;
                end
                if (aonExpire && !aonCtrl.reload) begin
                    aonRst_d = 1'b1;
                end
            end
            default: begin
                aonState_d = WD_IDLE;
            end
        endcase
    end

    // Reset request is sticky; the chip reset that follows clears it
    assign devRst_d = devRst_q | sysRst_q | aonRst_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            aonState_q <= WD_IDLE;
            aonCnt_q   <= CNT_RST;
            aonRst_q   <= 1'b0;
            devRst_q   <= 1'b0;
        end else begin
            aonState_q <= aonState_d;
            aonCnt_q   <= aonCnt_d;
            aonRst_q   <= aonRst_d;
            devRst_q   <= devRst_d;
        end
    end

    property p_aon_expire;
        aonExpire && !aonCtrl.reload |=> aonRst_q ##1 devResetReq;
    endproperty
    a_aon_expire: assert property (p_aon_expire)
        else $error("guard timer at zero did not request reset");

    property p_aon_keep_running;
        (aonState_q == WD_RUN) && aonCtrl.stopReq |=> (aonState_q == WD_RUN);
    endproperty
    a_aon_keep_running: assert property (p_aon_keep_running)
        else $error("guard timer stopped after start");

    property p_aon_counts;
        aonAdvance && !aonCtrl.reload && (aonCnt_q != CNT_RST)
            |=> aonCnt_q == $past(aonCnt_q) - CNT_ONE;
    endproperty
    a_aon_counts: assert property (p_aon_counts)
        else $error("guard timer did not decrement on tick");

    property p_aon_pause;
        (aonState_q == WD_RUN) && debugHalt && aonCtrl.pauseEn
            && !aonCtrl.reload |=> $stable(aonCnt_q);
    endproperty
    a_aon_pause: assert property (p_aon_pause)
        else $error("guard timer moved during paused debug halt");

    property p_aon_reload;
        (aonState_q == WD_RUN) && aonCtrl.reload
            |=> aonCnt_q == $past(aonLoad);
    endproperty
    a_aon_reload: assert property (p_aon_reload)
        else $error("guard reload did not restart count");

    // Status outputs, all from flip-flops
    assign sysStat = '{running:  (sysState_q == WD_RUN),
                       irq:      sysIrq_q,
                       resetReq: sysRst_q,
                       count:    sysCnt_q};
    assign aonStat = '{running:  (aonState_q == WD_RUN),
                       resetReq: aonRst_q,
                       count:    aonCnt_q};
    assign devResetReq      = devRst_q;

endmodule

// *** sim/dwt_top_tb.sv ***
// Self-checking bench for the system watchdog and always-on guard timer.
// Assumes dwt_pkg is compiled first; drives all inputs on the falling edge.
module dwt_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dwt_pkg::*;

    logic             clk;
    logic             rst;
    logic             debugHalt;
    logic [CNT_W-1:0] sysLoad;
    logic [CNT_W-1:0] aonLoad;
    dwt_sys_ctrl_t    sysCtrl;
    dwt_aon_ctrl_t    aonCtrl;
    dwt_sys_stat_t    sysStat;
    dwt_aon_stat_t    aonStat;
    logic             devResetReq;
    int               nFail;
    int               comparisons;
    int               cycles;
    logic [CNT_W-1:0] c0;
    logic [CNT_W-1:0] a0;

    dwt_top dwt_top_inst (
        .clk         (clk),
        .rst         (rst),
        .debugHalt   (debugHalt),
        .sysLoad     (sysLoad),
        .sysCtrl     (sysCtrl),
        .sysStat     (sysStat),
        .aonLoad     (aonLoad),
        .aonCtrl     (aonCtrl),
        .aonStat     (aonStat),
        .devResetReq (devResetReq)
    );

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard: the whole run needs under two thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            nFail++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end

    // Ticks are 3 per 20 clocks, so whole windows of 20 give exact drops
    function automatic logic [CNT_W-1:0] expDrop(input int n);
        return CNT_W'(3 * n / 20);
    endfunction

    task automatic chkB(input logic a, input logic e, input string m);
        comparisons++;
        if (a !== e) begin
            nFail++;
            $display("[ERR] %0t %s got %b exp %b", $time, m, a, e);
        end
    endtask

    task automatic chkW(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] e,
                        input string m);
        comparisons++;
        if (a !== e) begin
            nFail++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, a, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Reset, then one idle edge before any request may be given
    task automatic doReset(input int n);
        rst = 1'b1;
        sysCtrl = '0;
        aonCtrl = '0;
        debugHalt = 1'b0;
        cyc(n);
        rst = 1'b0;
        cyc(1);
    endtask

    // Start both timers with one-cycle pulses
    task automatic startBoth(input logic [CNT_W-1:0] s,
                             input logic [CNT_W-1:0] a);
        sysLoad = s;
        aonLoad = a;
        sysCtrl.start = 1'b1;
        aonCtrl.start = 1'b1;
        cyc(1);
        sysCtrl.start = 1'b0;
        aonCtrl.start = 1'b0;
    endtask

    // Wait on a selected status flag, bounded
    task automatic waitFlag(input int sel, input int lim, input string m);
        logic f;
        for (int i = 0; i < lim; i++) begin
            f = (sel == 0) ? sysStat.irq :
                (sel == 1) ? sysStat.resetReq : aonStat.resetReq;
            if (f === 1'b1) return;
            cyc(1);
        end
        chkB(1'b0, 1'b1, m);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        int k;
        nFail = 0;
        comparisons = 0;
        cycles = 0;
        sysLoad = '0;
        aonLoad = '0;
        void'($urandom(32'hB035));
        doReset(16);
        chkB(devResetReq, 1'b0, "idle reset out");
        chkB(sysStat.running, 1'b0, "idle running");
        $display("test reset done");
        // Random loads and windows: the count drop follows the timebase only
        for (int r = 0; r < 6; r++) begin
            startBoth($urandom | 32'h1000_0000, $urandom | 32'h1000_0000);
            chkW(sysStat.count, sysLoad, "sys load");
            chkW(aonStat.count, aonLoad, "aon load");
            k = 20 * (1 + $urandom_range(0, 9));
            cyc(k);
            c0 = sysLoad - expDrop(k);
            a0 = aonLoad - expDrop(k);
            chkW(sysStat.count, c0, "sys rate");
            chkW(aonStat.count, a0, "aon rate");
            if (r < 5) doReset(2);
        end
        $display("test rate done");
        // Stop and restart attempts held for a full window change nothing
        c0 = sysStat.count;
        a0 = aonStat.count;
        sysCtrl.stopReq = 1'b1;
        aonCtrl.stopReq = 1'b1;
        sysCtrl.start = 1'b1;
        sysLoad = 32'h0000_0005;
        cyc(20);
        sysCtrl = '0;
        aonCtrl = '0;
        chkB(sysStat.running, 1'b1, "sys stop refused");
        chkB(aonStat.running, 1'b1, "aon stop refused");
        chkW(sysStat.count, c0 - expDrop(20), "sys after stop");
        chkW(aonStat.count, a0 - expDrop(20), "aon after stop");
        $display("test stop done");
        // Debug halt: system freezes; guard timer freezes only with pauseEn
        for (int p = 0; p < 2; p++) begin
            aonCtrl.pauseEn = p[0];
            c0 = sysStat.count;
            a0 = aonStat.count;
            debugHalt = 1'b1;
            cyc(100);
            chkW(sysStat.count, c0, "sys halted");
            if (p == 0) a0 = a0 - expDrop(100);
            chkW(aonStat.count, a0, "aon halt");
            debugHalt = 1'b0;
            cyc(20);
            chkW(sysStat.count, c0 - expDrop(20), "sys resume");
        end
        aonCtrl.pauseEn = 1'b0;
        $display("test halt done");
        // System expiry: first raises irq, reload clears, next raises irq only, the unserviced one after forces reset
        doReset(2);
        sysCtrl.resetEn = 1'b1;
        startBoth(32'h0000_0002, 32'hFFFF_FFFF);
        waitFlag(0, 40, "first expiry");
        chkB(sysStat.irq, 1'b1, "irq raised");
        chkB(sysStat.resetReq, 1'b0, "no reset on first");
        chkW(sysStat.count, 32'h0000_0002, "reload on expiry");
        sysCtrl.reload = 1'b1;
        cyc(1);
        sysCtrl.reload = 1'b0;
        chkB(sysStat.irq, 1'b0, "irq cleared by reload");
        waitFlag(0, 40, "expiry after reload");
        chkB(sysStat.resetReq, 1'b0, "serviced, no reset");
        waitFlag(1, 40, "second expiry");
        chkB(sysStat.irq, 1'b1, "irq still set");
        cyc(1);
        chkB(devResetReq, 1'b1, "device reset sys");
        $display("test expiry done");
        // Clearing the interrupt alone keeps the next expiry from resetting
        doReset(2);
        sysCtrl.resetEn = 1'b1;
        startBoth(32'h0000_0002, 32'hFFFF_FFFF);
        waitFlag(0, 40, "expiry before clear");
        sysCtrl.intClear = 1'b1;
        cyc(1);
        sysCtrl.intClear = 1'b0;
        chkB(sysStat.irq, 1'b0, "irq cleared");
        chkW(sysStat.count, 32'h0000_0002, "clear keeps count");
        waitFlag(0, 40, "expiry after clear");
        chkB(sysStat.resetReq, 1'b0, "cleared, no reset");
        $display("test clear done");
        // Guard timer runs to zero despite a stop attempt, then resets
        doReset(2);
        startBoth(32'hFFFF_FFFF, 32'h0000_0003);
        aonCtrl.stopReq = 1'b1;
        // At most two ticks in ten clocks, so the reload lands before zero
        cyc(10);
        aonLoad = 32'h0000_0004;
        aonCtrl.reload = 1'b1;
        cyc(1);
        aonCtrl.reload = 1'b0;
        chkW(aonStat.count, 32'h0000_0004, "guard reload");
        waitFlag(2, 60, "guard expiry");
        aonCtrl.stopReq = 1'b0;
        chkW(aonStat.count, CNT_RST, "guard at zero");
        chkB(sysStat.resetReq, 1'b0, "sys quiet");
        cyc(1);
        chkB(devResetReq, 1'b1, "device reset aon");
        doReset(2);
        chkB(devResetReq, 1'b0, "reset clears request");
        $display("test guard done");
        results();
    end
endmodule
